// [src/tmx_consts.svh]
// Operation
// (RQ1) overflow selector picks one of five 24-bit registers
// (RQ2) timer selector picks one of five 16-bit registers
// (RQ3) timer low port accesses bits 7:0
// (RQ4) timer high port accesses bits 15:8
// (RQ5) timer low read latches count, latch mode 0
// (RQ6) latch mode 1: timer low read latches both
// (RQ7) timer high read at 000 returns held byte
// (RQ8) overflow low port accesses bits 7:0
// (RQ9) overflow low read latches overflow count, mode 0
// (RQ10) overflow middle read at 000 returns held bits
// (RQ11) overflow high port accesses bits 23:16, held
// (RQ12) flag 5 on overflow compare-two match
// (RQ13) flag 4 on overflow compare-one match
// (RQ14) overflow wraps at period, sets flag 3
// (RQ15) flag 2 on timer compare-two match
// (RQ16) flag 1 on timer compare-one match
// (RQ17) timer wraps at period, sets flag 0
// (RQ18) timer 16-bit upcounter, overflow registers 24-bit
// (RQ19) capture registers read-only, reset to zero
// (RQ20) latch mode resets 0, chooses snapshot source
// (RQ21) flags sticky, write zero clears, one keeps
// (RQ22) reserved codes select nothing, reserved bits zero
`ifndef TMX_CONSTS_SVH
`define TMX_CONSTS_SVH

// ----------------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------------
`define TMX_ADDR_FLAGS 8'ha1
`define TMX_ADDR_TIM_LO 8'ha2
`define TMX_ADDR_TIM_HI 8'ha3
`define TMX_ADDR_OVF_LO 8'ha4
`define TMX_ADDR_OVF_MID 8'ha5
`define TMX_ADDR_OVF_HI 8'ha6
`define TMX_ADDR_SEL 8'hc3

// ----------------------------------------------------------------------------
// fields and widths
// ----------------------------------------------------------------------------
`define TMX_TIM_W 16
`define TMX_OVF_W 24
`define TMX_SEL_TIM_LSB 0
`define TMX_SEL_OVF_LSB 4
`define TMX_SEL_MASK 8'h77
`define TMX_FLAG_MASK 8'h3f
`define TMX_FLAG_TIM_WRAP 0
`define TMX_FLAG_TIM_CMP1 1
`define TMX_FLAG_TIM_CMP2 2
`define TMX_FLAG_OVF_WRAP 3
`define TMX_FLAG_OVF_CMP1 4
`define TMX_FLAG_OVF_CMP2 5

// ----------------------------------------------------------------------------
// selector codes
// ----------------------------------------------------------------------------
`define TMX_SEL_CNT 3'h0
`define TMX_SEL_CAP 3'h1
`define TMX_SEL_PER 3'h2
`define TMX_SEL_CMP1 3'h3
`define TMX_SEL_CMP2 3'h4

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define TMX_RST_BYTE 8'h00
`define TMX_RST_TIM 16'h0000
`define TMX_RST_OVF 24'h000000

`endif

// [src/tmx_pkg.sv]
package tmx_pkg;
   typedef logic [7:0] tmx_byte_t;
   typedef logic [2:0] tmx_sel_t;

   // one special-function register access, same clock as the block
   typedef struct packed {
      logic [7:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } tmx_sfr_req_s;
endpackage : tmx_pkg

// [src/tmx_reset_sync.sv]
`timescale 1ns/1ns
module tmx_reset_sync (
   // clock and raw reset
   input wire logic clk,
   input wire logic nrst,
   // released reset
   output logic rstSyncN
);
   logic stage_reg;
   logic stage_next;
   logic out_next;

   always_comb begin
      stage_next = 1'b1;
      out_next = stage_reg;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stage_reg <= 1'b0;
         rstSyncN <= 1'b0;
      end else begin
         stage_reg <= stage_next;
         rstSyncN <= out_next;
      end
   end
endmodule : tmx_reset_sync

// [src/tmx_counter.sv]
`timescale 1ns/1ns
module tmx_counter #(
   parameter int W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstN,
   // control
   input wire logic countEn,
   input wire logic loadEn,
   input wire logic [W-1:0] loadVal,
   // settings
   input wire logic [W-1:0] period,
   input wire logic [W-1:0] compareOne,
   input wire logic [W-1:0] compareTwo,
   // state and events
   output logic [W-1:0] count,
   output logic wrapHit,
   output logic matchOne,
   output logic matchTwo
);
   logic [W-1:0] count_reg;
   logic [W-1:0] count_next;
   logic [W-1:0] step;

   if (W < 9 || W > 32) begin : g_chk
      $error("tmx_counter: width must be 9 to 32");
   end

   // ------------------------------------------------------------------------
   // up count with period wrap
   // ------------------------------------------------------------------------
   always_comb begin
      step = count_reg + {{(W-1){1'b0}}, 1'b1};
      count_next = count_reg;
      wrapHit = 1'b0;
      matchOne = 1'b0;
      matchTwo = 1'b0;
      if (loadEn) begin
         count_next = loadVal;
      end else if (countEn) begin
         if (step == period) begin
            count_next = '0; // [RQ14] [RQ17]
            wrapHit = 1'b1;
         end else begin
            count_next = step; // [RQ18]
         end
         matchOne = (count_next == compareOne);
         matchTwo = (count_next == compareTwo);
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   assign count = count_reg;
endmodule : tmx_counter

// [src/tmx_timer_front.sv]
`timescale 1ns/1ns
`include "tmx_consts.svh"
module tmx_timer_front (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // special-function register access
   input wire tmx_pkg::tmx_sfr_req_s sfrReq,
   output logic [7:0] sfrRdata,
   // timer control from the same clock
   input wire logic timerTick,
   input wire logic latchMode,
   input wire logic captureEvent,
   // state
   output logic [7:0] eventFlags,
   output logic [`TMX_TIM_W-1:0] timerCount,
   output logic [`TMX_OVF_W-1:0] overflowCount
);
   logic rstN;
   tmx_pkg::tmx_sel_t timSel;
   tmx_pkg::tmx_sel_t ovfSel;
   logic timPort;
   logic ovfPort;
   logic [1:0] ovfByte;
   logic timByte;

   // ------------------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------------------
   tmx_reset_sync u_rst (
      .clk(clk),
      .nrst(nrst),
      .rstSyncN(rstN)
   );

   // ------------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------------
   logic [7:0] sel_reg, sel_next;
   logic [7:0] flags_reg, flags_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [15:0] timPer_reg, timPer_next;
   logic [15:0] timCmp1_reg, timCmp1_next;
   logic [15:0] timCmp2_reg, timCmp2_next;
   logic [15:0] timCap_reg, timCap_next;
   logic [7:0] timHeld_reg, timHeld_next;
   logic [23:0] ovfPer_reg, ovfPer_next;
   logic [23:0] ovfCmp1_reg, ovfCmp1_next;
   logic [23:0] ovfCmp2_reg, ovfCmp2_next;
   logic [23:0] ovfCap_reg, ovfCap_next;
   logic [23:0] ovfHeld_reg, ovfHeld_next;

   // counter interface
   logic [15:0] timCnt;
   logic [23:0] ovfCnt;
   logic timLoad, ovfLoad;
   logic [15:0] timLoadVal;
   logic [23:0] ovfLoadVal;
   logic timWrap, timM1, timM2;
   logic ovfWrap, ovfM1, ovfM2;
   logic [15:0] timVal;
   logic [23:0] ovfVal;
   logic [7:0] flagSet;
   logic [7:0] flagKeep;

   assign timSel = sel_reg[`TMX_SEL_TIM_LSB +: 3];
   assign ovfSel = sel_reg[`TMX_SEL_OVF_LSB +: 3];

   // ------------------------------------------------------------------------
   // counters
   // ------------------------------------------------------------------------
   tmx_counter #(.W(`TMX_TIM_W)) u_tim (
      .clk(clk),
      .rstN(rstN),
      .countEn(timerTick),
      .loadEn(timLoad),
      .loadVal(timLoadVal),
      .period(timPer_reg),
      .compareOne(timCmp1_reg),
      .compareTwo(timCmp2_reg),
      .count(timCnt),
      .wrapHit(timWrap),
      .matchOne(timM1),
      .matchTwo(timM2)
   );

   tmx_counter #(.W(`TMX_OVF_W)) u_ovf (
      .clk(clk),
      .rstN(rstN),
      .countEn(timWrap),
      .loadEn(ovfLoad),
      .loadVal(ovfLoadVal),
      .period(ovfPer_reg),
      .compareOne(ovfCmp1_reg),
      .compareTwo(ovfCmp2_reg),
      .count(ovfCnt),
      .wrapHit(ovfWrap),
      .matchOne(ovfM1),
      .matchTwo(ovfM2)
   );

   assign timerCount = timCnt;
   assign overflowCount = ovfCnt;

   // ------------------------------------------------------------------------
   // selected internal registers
   // ------------------------------------------------------------------------
   always_comb begin
      case (timSel) // [RQ2]
         `TMX_SEL_CNT: timVal = timCnt;
         `TMX_SEL_CAP: timVal = timCap_reg;
         `TMX_SEL_PER: timVal = timPer_reg;
         `TMX_SEL_CMP1: timVal = timCmp1_reg;
         `TMX_SEL_CMP2: timVal = timCmp2_reg;
         default: timVal = `TMX_RST_TIM; // [RQ22]
      endcase
      case (ovfSel) // [RQ1]
         `TMX_SEL_CNT: ovfVal = ovfCnt;
         `TMX_SEL_CAP: ovfVal = ovfCap_reg;
         `TMX_SEL_PER: ovfVal = ovfPer_reg;
         `TMX_SEL_CMP1: ovfVal = ovfCmp1_reg;
         `TMX_SEL_CMP2: ovfVal = ovfCmp2_reg;
         default: ovfVal = `TMX_RST_OVF; // [RQ22]
      endcase
   end

   // ------------------------------------------------------------------------
   // port decode
   // ------------------------------------------------------------------------
   always_comb begin
      timPort = 1'b0;
      timByte = 1'b0;
      ovfPort = 1'b0;
      ovfByte = 2'h0;
      case (sfrReq.addr)
         `TMX_ADDR_TIM_LO: timPort = 1'b1; // [RQ3]
         `TMX_ADDR_TIM_HI: begin
            timPort = 1'b1;
            timByte = 1'b1; // [RQ4]
         end
         `TMX_ADDR_OVF_LO: ovfPort = 1'b1; // [RQ8]
         `TMX_ADDR_OVF_MID: begin
            ovfPort = 1'b1;
            ovfByte = 2'h1;
         end
         `TMX_ADDR_OVF_HI: begin
            ovfPort = 1'b1;
            ovfByte = 2'h2; // [RQ11]
         end
         default: begin
            timPort = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------------------
   // writes, snapshots, captures
   // ------------------------------------------------------------------------
   always_comb begin
      sel_next = sel_reg;
      timPer_next = timPer_reg;
      timCmp1_next = timCmp1_reg;
      timCmp2_next = timCmp2_reg;
      ovfPer_next = ovfPer_reg;
      ovfCmp1_next = ovfCmp1_reg;
      ovfCmp2_next = ovfCmp2_reg;
      timCap_next = timCap_reg;
      ovfCap_next = ovfCap_reg;
      timHeld_next = timHeld_reg;
      ovfHeld_next = ovfHeld_reg;
      timLoad = 1'b0;
      ovfLoad = 1'b0;
      timLoadVal = timCnt;
      ovfLoadVal = ovfCnt;
      if (sfrReq.wr && sfrReq.addr == `TMX_ADDR_SEL) begin
         sel_next = sfrReq.wdata & `TMX_SEL_MASK; // [RQ22]
      end
      if (sfrReq.wr && timPort) begin
         case (timSel)
            `TMX_SEL_CNT: begin
               timLoad = 1'b1;
               timLoadVal[8*timByte +: 8] = sfrReq.wdata;
            end
            `TMX_SEL_PER: timPer_next[8*timByte +: 8] = sfrReq.wdata;
            `TMX_SEL_CMP1: timCmp1_next[8*timByte +: 8] = sfrReq.wdata;
            `TMX_SEL_CMP2: timCmp2_next[8*timByte +: 8] = sfrReq.wdata;
            default: timLoad = 1'b0; // capture and reserved ignore writes [RQ19] [RQ22]
         endcase
      end
      if (sfrReq.wr && ovfPort) begin
         case (ovfSel)
            `TMX_SEL_CNT: begin
               ovfLoad = 1'b1;
               ovfLoadVal[8*ovfByte +: 8] = sfrReq.wdata;
            end
            `TMX_SEL_PER: ovfPer_next[8*ovfByte +: 8] = sfrReq.wdata;
            `TMX_SEL_CMP1: ovfCmp1_next[8*ovfByte +: 8] = sfrReq.wdata;
            `TMX_SEL_CMP2: ovfCmp2_next[8*ovfByte +: 8] = sfrReq.wdata;
            default: ovfLoad = 1'b0; // [RQ19] [RQ22]
         endcase
      end
      if (captureEvent) begin
         timCap_next = timCnt; // [RQ19]
         ovfCap_next = ovfCnt;
      end
      if (sfrReq.rd && sfrReq.addr == `TMX_ADDR_TIM_LO && timSel == `TMX_SEL_CNT) begin
         timHeld_next = timCnt[15:8]; // [RQ5]
         if (latchMode) begin
            ovfHeld_next = ovfCnt; // [RQ6] [RQ20]
         end
      end
      if (sfrReq.rd && sfrReq.addr == `TMX_ADDR_OVF_LO && ovfSel == `TMX_SEL_CNT
          && !latchMode) begin
         ovfHeld_next = ovfCnt; // [RQ9] [RQ20]
      end
   end

   // ------------------------------------------------------------------------
   // read data
   // ------------------------------------------------------------------------
   always_comb begin
      rdata_next = rdata_reg;
      if (sfrReq.rd) begin
         case (sfrReq.addr)
            `TMX_ADDR_FLAGS: rdata_next = flags_reg & `TMX_FLAG_MASK; // [RQ22]
            `TMX_ADDR_SEL: rdata_next = sel_reg;
            `TMX_ADDR_TIM_LO: rdata_next = timVal[7:0]; // [RQ3]
            `TMX_ADDR_TIM_HI: begin
               if (timSel == `TMX_SEL_CNT) begin
                  rdata_next = timHeld_reg; // [RQ7]
               end else begin
                  rdata_next = timVal[15:8]; // [RQ4]
               end
            end
            `TMX_ADDR_OVF_LO: begin
               if (ovfSel == `TMX_SEL_CNT && latchMode) begin
                  rdata_next = ovfHeld_reg[7:0]; // [RQ6]
               end else begin
                  rdata_next = ovfVal[7:0]; // [RQ8]
               end
            end
            `TMX_ADDR_OVF_MID: begin
               if (ovfSel == `TMX_SEL_CNT) begin
                  rdata_next = ovfHeld_reg[15:8]; // [RQ10]
               end else begin
                  rdata_next = ovfVal[15:8];
               end
            end
            `TMX_ADDR_OVF_HI: begin
               if (ovfSel == `TMX_SEL_CNT) begin
                  rdata_next = ovfHeld_reg[23:16]; // [RQ11]
               end else begin
                  rdata_next = ovfVal[23:16];
               end
            end
            default: rdata_next = `TMX_RST_BYTE;
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // sticky event flags
   // ------------------------------------------------------------------------
   always_comb begin
      flagSet = `TMX_RST_BYTE;
      flagSet[`TMX_FLAG_OVF_CMP2] = ovfM2; // [RQ12]
      flagSet[`TMX_FLAG_OVF_CMP1] = ovfM1; // [RQ13]
      flagSet[`TMX_FLAG_OVF_WRAP] = ovfWrap; // [RQ14]
      flagSet[`TMX_FLAG_TIM_CMP2] = timM2; // [RQ15]
      flagSet[`TMX_FLAG_TIM_CMP1] = timM1; // [RQ16]
      flagSet[`TMX_FLAG_TIM_WRAP] = timWrap; // [RQ17]
      flagKeep = 8'hff;
      if (sfrReq.wr && sfrReq.addr == `TMX_ADDR_FLAGS) begin
         flagKeep = sfrReq.wdata; // [RQ21]
      end
      flags_next = ((flags_reg & flagKeep) | flagSet) & `TMX_FLAG_MASK; // [RQ21]
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         sel_reg <= `TMX_RST_BYTE;
         flags_reg <= `TMX_RST_BYTE;
         rdata_reg <= `TMX_RST_BYTE;
         timPer_reg <= `TMX_RST_TIM;
         timCmp1_reg <= `TMX_RST_TIM;
         timCmp2_reg <= `TMX_RST_TIM;
         timCap_reg <= `TMX_RST_TIM;
         timHeld_reg <= `TMX_RST_BYTE;
         ovfPer_reg <= `TMX_RST_OVF;
         ovfCmp1_reg <= `TMX_RST_OVF;
         ovfCmp2_reg <= `TMX_RST_OVF;
         ovfCap_reg <= `TMX_RST_OVF;
         ovfHeld_reg <= `TMX_RST_OVF;
      end else begin
         sel_reg <= sel_next;
         flags_reg <= flags_next;
         rdata_reg <= rdata_next;
         timPer_reg <= timPer_next;
         timCmp1_reg <= timCmp1_next;
         timCmp2_reg <= timCmp2_next;
         timCap_reg <= timCap_next;
         timHeld_reg <= timHeld_next;
         ovfPer_reg <= ovfPer_next;
         ovfCmp1_reg <= ovfCmp1_next;
         ovfCmp2_reg <= ovfCmp2_next;
         ovfCap_reg <= ovfCap_next;
         ovfHeld_reg <= ovfHeld_next;
      end
   end

   assign sfrRdata = rdata_reg;
   assign eventFlags = flags_reg;
endmodule : tmx_timer_front

// [sim/tmx_timer_front_assertions.sv]
`timescale 1ns/1ns
module tmx_timer_front_assertions (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register access
   input wire tmx_pkg::tmx_sfr_req_s sfrReq,
   input wire logic [7:0] sfrRdata,
   // timer control
   input wire logic timerTick,
   input wire logic latchMode,
   input wire logic captureEvent,
   // state
   input wire logic [7:0] eventFlags,
   input wire logic [15:0] timerCount,
   input wire logic [23:0] overflowCount
);
   // ------
   // checks
   // ------
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   flag_top_zero_a: assert property (eventFlags[7:6] == 2'h0)
      else $error("flag bits 7:6 not zero");
   flag_sticky_a: assert property (eventFlags[0] && !(sfrReq.wr &&
      sfrReq.addr == 8'ha1 && !sfrReq.wdata[0]) |=> eventFlags[0])
      else $error("wrap flag dropped without clear");
   count_step_a: assert property (timerTick && !sfrReq.wr |=>
      timerCount == $past(timerCount) + 16'h0001 || timerCount == 16'h0000)
      else $error("timer did not step by one");
   count_hold_a: assert property (!timerTick && !sfrReq.wr |=> $stable(timerCount))
      else $error("timer moved without tick");
   ovf_by_wrap_a: assert property (!sfrReq.wr ##1 !$stable(overflowCount) |->
      timerCount == 16'h0000)
      else $error("overflow count moved without timer wrap");
   tim_wrap_a: assert property ($rose(eventFlags[0]) |-> timerCount == 16'h0000)
      else $error("wrap flag without zero count");
   ovf_wrap_a: assert property ($rose(eventFlags[3]) |->
      overflowCount == 24'h000000 && timerCount == 16'h0000)
      else $error("overflow wrap flag without zero counts");
   rd_unmapped_a: assert property (sfrReq.rd &&
      !(sfrReq.addr inside {[8'ha1:8'ha6], 8'hc3}) |=> sfrRdata == 8'h00)
      else $error("unmapped read not zero");
   rd_flags_a: assert property (sfrReq.rd && sfrReq.addr == 8'ha1 |=>
      sfrRdata == $past(eventFlags))
      else $error("flag read mismatch");
   rd_hold_a: assert property (!sfrReq.rd |=> $stable(sfrRdata))
      else $error("read data moved without read");
endmodule : tmx_timer_front_assertions

bind tmx_timer_front tmx_timer_front_assertions chk_u (.clk(clk), .nrst(nrst),
   .sfrReq(sfrReq), .sfrRdata(sfrRdata), .timerTick(timerTick), .latchMode(latchMode),
   .captureEvent(captureEvent), .eventFlags(eventFlags), .timerCount(timerCount),
   .overflowCount(overflowCount));

// [sim/tb_timer_mux_access_and_flags.sv]
`timescale 1ns/1ns
module tb_timer_mux_access_and_flags;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   tmx_pkg::tmx_sfr_req_s sfrReq = '0;
   logic [7:0] sfrRdata;
   logic timerTick = 1'b0;
   logic latchMode = 1'b0;
   logic captureEvent = 1'b0;
   logic [7:0] eventFlags;
   logic [15:0] timerCount;
   logic [23:0] overflowCount;
   int badCount = 0;
   int checkCount = 0;
   logic [7:0] regList [9] = '{8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'hc3, 8'h00, 8'ha7};

   always #20 clk = ~clk;

   tmx_timer_front dut_u (.clk(clk), .nrst(nrst), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
      .timerTick(timerTick), .latchMode(latchMode), .captureEvent(captureEvent),
      .eventFlags(eventFlags), .timerCount(timerCount), .overflowCount(overflowCount));

   // ------
   // helpers
   // ------
   task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
      checkCount++;
      if (got !== exp) begin
         badCount++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chkByte

   task automatic chkCnt(input logic [23:0] got, input logic [23:0] exp);
      checkCount++;
      if (got !== exp) begin
         badCount++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chkCnt

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfrReq <= '{addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
      @(posedge clk);
      sfrReq.wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      sfrReq <= '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
      @(posedge clk);
      sfrReq.rd <= 1'b0;
      #1 chkByte(sfrRdata, exp);
   endtask : rd

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         timerTick <= 1'b1;
      end
      @(posedge clk);
      timerTick <= 1'b0;
      #1;
   endtask : tick

   task automatic summarize;
      $display("checks=%0d mismatches=%0d", checkCount, badCount);
      if (badCount == 0 && checkCount > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize

   // ------
   // scenarios
   // ------
   task automatic resetCheck;
      foreach (regList[i]) rd(regList[i], 8'h00);
      wr(8'hc3, 8'hff);
      rd(8'hc3, 8'h77);
      wr(8'ha2, 8'hab);
      wr(8'ha4, 8'hab);
      rd(8'ha2, 8'h00);
      rd(8'ha4, 8'h00);
      chkCnt({8'h00, timerCount}, 24'h000000);
      chkCnt(overflowCount, 24'h000000);
   endtask : resetCheck

   task automatic windowCheck;
      logic [15:0] tv;
      logic [23:0] ov;
      for (int c = 1; c <= 4; c++) begin
         tv = 16'ha5c0 + 16'(c);
         ov = 24'h5a3c00 + 24'(c);
         wr(8'hc3, {1'b0, 3'(c), 1'b0, 3'(c)});
         wr(8'ha2, tv[7:0]);
         wr(8'ha3, tv[15:8]);
         wr(8'ha4, ov[7:0]);
         wr(8'ha5, ov[15:8]);
         wr(8'ha6, ov[23:16]);
         if (c == 1) begin
            tv = '0;
            ov = '0;
         end
         rd(8'ha2, tv[7:0]);
         rd(8'ha3, tv[15:8]);
         rd(8'ha4, ov[7:0]);
         rd(8'ha5, ov[15:8]);
         rd(8'ha6, ov[23:16]);
         wr(8'ha2, 8'(c == 2 ? 5 : c - 1));
         wr(8'ha3, 8'h00);
         wr(8'ha4, 8'(c == 2 ? 3 : c - 2));
         wr(8'ha5, 8'h00);
         wr(8'ha6, 8'h00);
      end
   endtask : windowCheck

   task automatic countCheck;
      logic [7:0] f;
      int t;
      int o;
      f = 8'h00;
      wr(8'ha1, 8'h00);
      for (int i = 1; i <= 15; i++) begin
         tick(1);
         t = i % 5;
         o = (i / 5) % 3;
         if (t == 2) f[1] = 1'b1;
         if (t == 3) f[2] = 1'b1;
         if (t == 0) begin
            f[0] = 1'b1;
            f[3] = f[3] | (o == 0);
            f[4] = f[4] | (o == 1);
            f[5] = f[5] | (o == 2);
         end
         chkCnt({8'h00, timerCount}, 24'(t));
         chkCnt(overflowCount, 24'(o));
         chkByte(eventFlags, f);
      end
      rd(8'ha1, 8'h3f);
      wr(8'ha1, 8'h3e);
      chkByte(eventFlags, 8'h3e);
      wr(8'ha1, 8'h00);
      chkByte(eventFlags, 8'h00);
   endtask : countCheck

   task automatic snapshotCheck;
      wr(8'hc3, 8'h00);
      wr(8'ha3, 8'h12);
      wr(8'ha2, 8'hfe);
      chkCnt({8'h00, timerCount}, 24'h0012fe);
      rd(8'ha2, 8'hfe);
      tick(3);
      rd(8'ha3, 8'h12);
      wr(8'ha6, 8'h03);
      wr(8'ha5, 8'h02);
      wr(8'ha4, 8'h01);
      rd(8'ha4, 8'h01);
      wr(8'ha5, 8'h77);
      chkCnt(overflowCount, 24'h037701);
      rd(8'ha5, 8'h02);
      rd(8'ha6, 8'h03);
      @(posedge clk);
      latchMode <= 1'b1;
      rd(8'ha2, 8'h01);
      wr(8'ha4, 8'h55);
      wr(8'ha6, 8'h66);
      rd(8'ha4, 8'h01);
      rd(8'ha5, 8'h77);
      rd(8'ha6, 8'h03);
      @(posedge clk);
      captureEvent <= 1'b1;
      @(posedge clk);
      captureEvent <= 1'b0;
      wr(8'hc3, 8'h11);
      rd(8'ha3, 8'h13);
      rd(8'ha6, 8'h66);
   endtask : snapshotCheck

   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      resetCheck();
      windowCheck();
      countCheck();
      snapshotCheck();
      summarize();
   end

   initial begin
      #2000000;
      badCount++;
      summarize();
   end
endmodule : tb_timer_mux_access_and_flags
